// *** hw/swd_decoder.sv ***
// Servo wedge decoder with read path byte packer and output FIFO.
// Assumes servo pulses and read channel pins are asynchronous and that
// burst amplitude and actuator current come from logic on sys_clk.
`timescale 1ns/1ps

// Plain FIFO, count based, valid/ready on both sides
module swd_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];       // Storage
  logic [AW-1:0] wp_ff;            // Write pointer
  logic [AW-1:0] rp_ff;            // Read pointer
  logic [AW:0]   cnt_ff;           // Fill level
  logic push;
  logic pop;
  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rp_ff];
  assign push = in_valid & in_ready;
  assign pop  = out_valid & out_ready;
  // Storage write
  always_ff @(posedge sys_clk)
  begin
    if (push) mem[wp_ff] <= in_data;
  end
  // Pointers and level
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push) wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      if (pop)  rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : swd_fifo

// Functional notes
// - Count 78 wedges per revolution.
// - Digit timing from one 37.5 ns reference.
// - Decode one and zero eight-digit patterns.
// - Fields in order sync, mark, track, bursts.
// - Lock on three-digit sync pattern.
// - Mark is two 14-digit patterns plus zero.
// - Index bit one yields index pulse.
// - Read 12-bit Gray track number.
// - Bursts in order A, B, C.
// - 42-digit bursts, 9-digit erase gaps.
// - Coarse position from track and A/B.
// - Fine position from A and C.
// - Velocity from track delta and current.
// - Mode chosen by seek length and state.
// - Decode 1,7 code, pack bytes, match ID.
// - Flag single or double burst correction.
module swd_decoder
  import swd_pkg::*;
#(
  parameter int SECT_BYTES = 512,   // Data bytes per sector
  parameter int FIFO_DEPTH = 32     // Read FIFO depth
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  input  wire logic                servo_pulse,    // Raw servo pulse pin
  input  wire logic                rd_clk_pin,     // Read reference clock pin
  input  wire logic                rd_code_pin,    // Coded read bit pin
  input  wire logic                rd_gate_pin,    // Sector read frame pin
  input  wire logic [7:0]          burst_amp,      // Burst peak sample
  input  wire logic signed [9:0]   act_current,    // Actuator current
  input  wire logic [11:0]         seek_tracks,    // Seek length request
  input  wire logic                on_track,       // Firmware on-track flag
  input  wire logic                settle_fine,    // Fine settle phase
  input  wire logic [7:0]          target_id,      // Wanted sector ID
  input  wire logic                rd_ready,       // Byte sink ready
  output logic                     index_ff,       // Index pulse
  output logic                     sample_ff,      // New position pulse
  output logic                     missed_ff,      // Wedge missed pulse
  output logic [6:0]               wedge_ff,       // Wedge number
  output logic [11:0]              track_ff,       // Binary track
  output logic [20:0]              position_ff,    // Track and fraction
  output logic signed [15:0]       velocity_ff,    // Velocity estimate
  output swd_mode_t                mode_ff,        // Servo mode
  output logic                     gate_a_ff,      // Burst A gate
  output logic                     gate_b_ff,      // Burst B gate
  output logic                     gate_c_ff,      // Burst C gate
  output logic                     rd_valid_ff,    // Byte valid
  output logic [7:0]               rd_byte_ff,     // Byte
  output logic [1:0]               ecc_need_ff,    // 0 none 1 single 2 double
  output logic                     sect_done_ff,   // Sector checked pulse
  output logic                     overrun_ff      // Byte lost, sticky
);
  // Gray to binary, MSB first
  function automatic logic [11:0] g2b(input logic [11:0] g);
    logic [11:0] b;
    b[11] = g[11];
    for (int i = 10; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction : g2b

  // Three-stage pin synchronisers with agreement filter
  logic [3:0] s1_ff, s2_ff, s3_ff, filt_ff, filt_d_ff;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_ff     <= '0;
      s2_ff     <= '0;
      s3_ff     <= '0;
      filt_ff   <= '0;
      filt_d_ff <= '0;
    end
    else
    begin
      s1_ff     <= {rd_gate_pin, rd_code_pin, rd_clk_pin, servo_pulse};
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      filt_ff   <= (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
      filt_d_ff <= filt_ff;
    end
  end
  wire pulse_edge = filt_ff[0] & ~filt_d_ff[0];

  // Digit enable from fractional picosecond accumulator
  logic [15:0] acc_ff;          // Phase within digit
  logic        digit_en_ff;     // One cycle per digit
  logic [16:0] nxt_acc;
  assign nxt_acc = {1'b0, acc_ff} + 17'(SYS_PS);
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acc_ff      <= '0;
      digit_en_ff <= 1'b0;
    end
    else if (nxt_acc >= 17'(DIGIT_PS))
    begin
      acc_ff      <= 16'(nxt_acc - 17'(DIGIT_PS));
      digit_en_ff <= 1'b1;
    end
    else
    begin
      acc_ff      <= nxt_acc[15:0];
      digit_en_ff <= 1'b0;
    end
  end

  // Pulse seen within the current digit, and digit history
  logic        seen_ff;
  logic [35:0] dig_ff;
  wire         d_new = seen_ff | pulse_edge;
  wire  [35:0] win   = {dig_ff[34:0], d_new};
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seen_ff <= 1'b0;
      dig_ff  <= '0;
    end
    else if (digit_en_ff)
    begin
      seen_ff <= 1'b0;
      dig_ff  <= win;
    end
    else if (pulse_edge)
      seen_ff <= 1'b1;
  end
  wire is_one  = (win[7:0] == BIT_ONE);
  wire is_zero = (win[7:0] == BIT_ZERO);
  wire sync_ok = (win[5:0] == SYNC_PAT) || (win[5:0] == (SYNC_PAT >> 1))
              || (win[5:0] == (SYNC_PAT >> 2));
  wire mark_hit = (win == MARK_PAT);

  // Wedge sequencer
  swd_state_t  st_ff;
  logic [7:0]  cnt_ff;          // Digit count within field
  logic [3:0]  bit_ff;          // Track bits taken
  logic [11:0] gray_ff;         // Gray shift register
  logic [7:0]  pk_a_ff, pk_b_ff, pk_c_ff;  // Burst peaks
  logic [11:0] prev_trk_ff;     // Previous track
  logic        fin_ff;          // Burst area complete
  wire         at_end = digit_en_ff & (cnt_ff == 8'(BIT_END));
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff     <= SWD_HUNT;
      cnt_ff    <= '0;
      bit_ff    <= '0;
      gray_ff   <= '0;
      index_ff  <= 1'b0;
      missed_ff <= 1'b0;
      fin_ff    <= 1'b0;
    end
    else
    begin
      index_ff  <= 1'b0;
      missed_ff <= 1'b0;
      fin_ff    <= 1'b0;
      if (digit_en_ff)
      begin
        cnt_ff <= cnt_ff + 1'b1;
        unique case (st_ff)
          SWD_HUNT:
          begin
            cnt_ff <= sync_ok ? cnt_ff + 1'b1 : '0;
            if (sync_ok && cnt_ff == 8'(SYNC_MIN))
            begin
              st_ff  <= SWD_MARK;
              cnt_ff <= '0;
            end
          end
          SWD_MARK:
          begin
            if (mark_hit)
            begin
              st_ff  <= SWD_INDEX;
              cnt_ff <= '0;
            end
            else if (cnt_ff == 8'(MARK_WIN))
            begin
              st_ff     <= SWD_HUNT;
              missed_ff <= 1'b1;
              cnt_ff    <= '0;
            end
          end
          SWD_INDEX:
          begin
            if (cnt_ff == 8'(BIT_END))
            begin
              index_ff <= is_one;
              cnt_ff   <= '0;
              bit_ff   <= '0;
              st_ff    <= (is_one | is_zero) ? SWD_TRACK : SWD_HUNT;
              missed_ff <= ~(is_one | is_zero);
            end
          end
          SWD_TRACK:
          begin
            if (cnt_ff == 8'(BIT_END))
            begin
              gray_ff <= {gray_ff[10:0], is_one};
              bit_ff  <= bit_ff + 1'b1;
              if (!(is_one | is_zero))
              begin
                st_ff     <= SWD_HUNT;
                missed_ff <= 1'b1;
                cnt_ff    <= '0;
              end
            end
            else if (cnt_ff == 8'(TRK_DBIT - 1))
            begin
              cnt_ff <= '0;
              if (bit_ff == 4'(TRK_BITS)) st_ff <= SWD_BURST;
            end
          end
          SWD_BURST:
          begin
            if (cnt_ff == 8'(AREA_LEN - 1))
            begin
              st_ff  <= SWD_HUNT;
              cnt_ff <= '0;
              fin_ff <= 1'b1;
            end
          end
          default:
          begin
            st_ff  <= SWD_HUNT;
            cnt_ff <= '0;
          end
        endcase
      end
    end
  end

  // Burst gates A, B, C between erase gaps
  localparam logic [7:0] A_ON = 8'(ERASE_LEN);
  localparam logic [7:0] B_ON = 8'(ERASE_LEN + BURST_LEN);
  localparam logic [7:0] C_ON = 8'(ERASE_LEN + 2 * BURST_LEN);
  localparam logic [7:0] C_OF = 8'(ERASE_LEN + 3 * BURST_LEN);
  wire in_b = (st_ff == SWD_BURST);
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gate_a_ff <= 1'b0;
      gate_b_ff <= 1'b0;
      gate_c_ff <= 1'b0;
      pk_a_ff   <= '0;
      pk_b_ff   <= '0;
      pk_c_ff   <= '0;
    end
    else
    begin
      gate_a_ff <= in_b && cnt_ff >= A_ON && cnt_ff < B_ON;
      gate_b_ff <= in_b && cnt_ff >= B_ON && cnt_ff < C_ON;
      gate_c_ff <= in_b && cnt_ff >= C_ON && cnt_ff < C_OF;
      if (st_ff == SWD_TRACK)
      begin
        pk_a_ff <= '0;
        pk_b_ff <= '0;
        pk_c_ff <= '0;
      end
      if (gate_a_ff && burst_amp > pk_a_ff) pk_a_ff <= burst_amp;
      if (gate_b_ff && burst_amp > pk_b_ff) pk_b_ff <= burst_amp;
      if (gate_c_ff && burst_amp > pk_c_ff) pk_c_ff <= burst_amp;
    end
  end

  // Position, velocity, wedge count and mode
  wire [11:0] trk_new = g2b(gray_ff);
  wire [8:0]  fine    = 9'(FINE_MID + {1'b0, pk_a_ff} - {1'b0, pk_c_ff});
  wire [7:0]  coarse  = trk_new[0] ? pk_a_ff : pk_b_ff;
  wire signed [15:0] dtrk = 16'(signed'({1'b0, trk_new}) - signed'({1'b0, prev_trk_ff}));
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sample_ff   <= 1'b0;
      wedge_ff    <= '0;
      track_ff    <= '0;
      prev_trk_ff <= '0;
      position_ff <= '0;
      velocity_ff <= '0;
      mode_ff     <= SWD_FOLLOW;
    end
    else
    begin
      sample_ff <= fin_ff;
      if (on_track) mode_ff <= SWD_FOLLOW;
      else if (seek_tracks >= 12'(SEEK_VEL)) mode_ff <= SWD_VEL;
      else mode_ff <= settle_fine ? SWD_FINE : SWD_COARSE;
      if (index_ff) wedge_ff <= '0;
      else if (fin_ff)
        wedge_ff <= (wedge_ff == 7'(WEDGES - 1)) ? '0 : wedge_ff + 1'b1;
      if (fin_ff)
      begin
        track_ff    <= trk_new;
        prev_trk_ff <= trk_new;
        if (mode_ff == SWD_VEL || mode_ff == SWD_COARSE)
          position_ff <= {track_ff[11:0] ^ track_ff ^ trk_new, coarse, 1'b0};
        else
          position_ff <= {trk_new, fine};
        velocity_ff <= (dtrk <<< 8) + 16'(act_current);
      end
    end
  end

  // Read path: 1,7 code triplets to bit pairs, then bytes
  logic [2:0] code_ff;          // Code shift
  logic [1:0] cph_ff;           // Code phase
  logic [7:0] sh_ff;            // Byte shift
  logic [1:0] pr_ff;            // Pairs in byte
  logic [9:0] nb_ff;            // Bytes in sector
  logic       match_ff;         // ID matched
  logic [7:0] syn_e_ff, syn_o_ff; // Interleaved syndromes
  logic       push;
  logic [7:0] wr_byte_ff;       // Byte being pushed into the FIFO
  logic       fifo_rdy;
  logic [1:0] pair;
  wire clk_edge  = filt_ff[1] & ~filt_d_ff[1];
  wire gate_rise = filt_ff[3] & ~filt_d_ff[3];
  wire [2:0] trip = {code_ff[1:0], filt_ff[2]};
  always_comb
  begin
    unique case (trip)
      3'h5:    pair = 2'h0;
      3'h4:    pair = 2'h1;
      3'h1:    pair = 2'h2;
      default: pair = 2'h3;
    endcase
  end
  wire byte_done = clk_edge && cph_ff == 2'h2 && pr_ff == 2'h3;
  wire [7:0] nbyte = {sh_ff[5:0], pair};
  // Syndromes including the byte now completing, for the final verdict
  wire [7:0] syn_e_nx = nb_ff[0] ? syn_e_ff ^ nbyte : syn_e_ff;
  wire [7:0] syn_o_nx = nb_ff[0] ? syn_o_ff : syn_o_ff ^ nbyte;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      code_ff <= '0; cph_ff <= '0; sh_ff <= '0; pr_ff <= '0;
      nb_ff <= '0; match_ff <= 1'b0; syn_e_ff <= '0; syn_o_ff <= '0;
      push <= 1'b0; wr_byte_ff <= '0; ecc_need_ff <= '0;
      sect_done_ff <= 1'b0; overrun_ff <= 1'b0;
    end
    else
    begin
      push         <= 1'b0;
      sect_done_ff <= 1'b0;
      if (push && !fifo_rdy) overrun_ff <= 1'b1;
      if (gate_rise)
      begin
        cph_ff <= '0; pr_ff <= '0; nb_ff <= '0;
        syn_e_ff <= '0; syn_o_ff <= '0; match_ff <= 1'b0;
      end
      else if (clk_edge && filt_ff[3])
      begin
        code_ff <= trip;
        cph_ff  <= (cph_ff == 2'h2) ? 2'h0 : cph_ff + 1'b1;
        if (cph_ff == 2'h2)
        begin
          sh_ff <= nbyte;
          pr_ff <= pr_ff + 1'b1;
        end
        if (byte_done)
        begin
          nb_ff <= nb_ff + 1'b1;
          if (nb_ff == '0) match_ff <= (nbyte == target_id);
          else
          begin
            if (nb_ff[0]) syn_e_ff <= syn_e_ff ^ nbyte;
            else syn_o_ff <= syn_o_ff ^ nbyte;
            if (match_ff && nb_ff <= 10'(SECT_BYTES))
            begin
              push       <= 1'b1;
              wr_byte_ff <= nbyte;
            end
          end
          if (nb_ff == 10'(SECT_BYTES + 2) && match_ff)
          begin
            sect_done_ff <= 1'b1;
            ecc_need_ff  <= 2'(syn_e_nx != '0) + 2'(syn_o_nx != '0);
          end
        end
      end
    end
  end

  // Output FIFO; ready feeds the overrun flag
  logic       f_valid;
  logic [7:0] f_data;
  swd_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .in_valid (push),
    .in_ready (fifo_rdy),
    .in_data  (wr_byte_ff),
    .out_valid(f_valid),
    .out_ready(rd_ready & ~rd_valid_ff),
    .out_data (f_data)
  );
  // Pop one byte into the output register, one pulse per byte
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_valid_ff <= 1'b0;
      rd_byte_ff  <= '0;
    end
    else
    begin
      rd_valid_ff <= f_valid & rd_ready & ~rd_valid_ff;
      if (f_valid & rd_ready & ~rd_valid_ff) rd_byte_ff <= f_data;
    end
  end

  // Checks
  wedge_range_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wedge_ff < 7'(WEDGES)) else $error("wedge count out of range");
  digit_space_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    digit_en_ff |=> !digit_en_ff [*8]) else $error("digit enable too close");
  sequence s_index_one;
    st_ff == SWD_INDEX && at_end && is_one;
  endsequence
  index_one_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_index_one |=> index_ff ##1 !index_ff) else $error("index pulse missing");
  order_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_ff == SWD_TRACK |-> $past(st_ff) inside {SWD_INDEX, SWD_TRACK})
    else $error("track field out of order");
  mark_go_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_ff == SWD_MARK && digit_en_ff && mark_hit |=> st_ff == SWD_INDEX)
    else $error("mark not taken");
  gray_conv_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fin_ff |=> track_ff == g2b($past(gray_ff))) else $error("track conversion");
  gate_excl_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    gate_a_ff |-> !gate_b_ff && !gate_c_ff) else $error("burst gates overlap");
  miss_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    missed_ff |=> $stable(track_ff)) else $error("track changed on miss");
  mode_vel_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !on_track && seek_tracks >= 12'(SEEK_VEL) |=> mode_ff == SWD_VEL)
    else $error("velocity mode not chosen");
endmodule : swd_decoder

// *** hw/swd_pkg.sv ***
// Constants shared by the servo wedge decoder.
// Assumes a 250 MHz system clock; times are held in picoseconds.
package swd_pkg;
  localparam int unsigned SYS_PS    = 4000;   // System clock period
  localparam int unsigned DIGIT_PS  = 37500;  // Servo digit period
  localparam int unsigned WEDGES    = 78;     // Wedges per revolution
  localparam int unsigned SYNC_LEN  = 99;     // Gain/sync field, digits
  localparam int unsigned SYNC_MIN  = 30;     // Periodic digits to lock
  localparam int unsigned MARK_LEN  = 46;     // Mark field, digits
  localparam int unsigned MARK_WIN  = SYNC_LEN + MARK_LEN; // Search window
  localparam int unsigned TRK_BITS  = 12;     // Track number width
  localparam int unsigned TRK_LEN   = 108;    // Track field, digits
  localparam int unsigned TRK_DBIT  = TRK_LEN / TRK_BITS; // Digits per bit
  localparam int unsigned ERASE_LEN = 9;      // Erase gap, digits
  localparam int unsigned BURST_LEN = 42;     // One burst, digits
  localparam int unsigned AREA_LEN  = 144;    // Burst area, digits
  localparam int unsigned SEEK_VEL  = 20;     // Least velocity seek
  localparam int unsigned BIT_END   = 7;      // Last digit of a bit
  localparam logic [7:0]  BIT_ONE   = 8'h90;  // 1,0,0,1,0,0,0,0
  localparam logic [7:0]  BIT_ZERO  = 8'h84;  // 1,0,0,0,0,1,0,0
  localparam logic [35:0] MARK_PAT  = 36'h800200084; // 2x14 digits + zero
  localparam logic [5:0]  SYNC_PAT  = 6'h24;  // Three-digit period
  localparam logic [8:0]  FINE_MID  = 9'h100; // Fine position centre
  // Servo modes
  typedef enum logic [1:0] {
    SWD_VEL    = 2'h0,
    SWD_COARSE = 2'h1,
    SWD_FINE   = 2'h2,
    SWD_FOLLOW = 2'h3
  } swd_mode_t;
  // Wedge states, Gray ordered along the wedge
  typedef enum logic [2:0] {
    SWD_HUNT  = 3'h0,
    SWD_MARK  = 3'h1,
    SWD_INDEX = 3'h3,
    SWD_TRACK = 3'h2,
    SWD_BURST = 3'h6
  } swd_state_t;
endpackage : swd_pkg

// *** sim/servo_wedge_decoder_tb.sv ***
// Testbench for the servo wedge decoder: wedge table, then hand cases.
// Assumes swd_chan_model drives servo and read pins asynchronously.
`timescale 1ns/1ps
module servo_wedge_decoder_tb
  import swd_pkg::*;
;
  localparam int SECT_N = 36;  // Sector length, above the FIFO depth
  typedef struct packed {
    logic        idx;
    logic [11:0] trk;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  c;
    logic [11:0] seek;
    logic        on;
    logic        fine;
    logic [9:0]  cur;
    swd_mode_t   mode;
  } swd_row_t;
  swd_row_t rows [6] = '{
    '{1'b1, 12'h7fe, 8'h40, 8'hff, 8'h40, 12'h01e, 1'b0, 1'b0, 10'h003, SWD_VEL},
    '{1'b0, 12'h7ff, 8'h22, 8'h00, 8'h40, 12'h005, 1'b0, 1'b0, 10'h3fe, SWD_COARSE},
    '{1'b0, 12'h800, 8'h30, 8'h77, 8'h50, 12'h005, 1'b0, 1'b1, 10'h000, SWD_FINE},
    '{1'b0, 12'h801, 8'h80, 8'h80, 8'h80, 12'h000, 1'b1, 1'b0, 10'h010, SWD_FOLLOW},
    '{1'b0, 12'h7ff, 8'h00, 8'h10, 8'hff, 12'h000, 1'b1, 1'b1, 10'h000, SWD_FOLLOW},
    '{1'b0, 12'h800, 8'h11, 8'h12, 8'h00, 12'h014, 1'b0, 1'b0, 10'h3f0, SWD_VEL}};
  logic sys_clk = 1'b0, rst_b = 1'b0, rd_ready = 1'b1, on_track = 1'b0, settle_fine = 1'b0;
  logic [11:0] seek_tracks = 12'h000;
  logic [7:0]  target_id   = 8'h5a;
  logic signed [9:0] act_current = 10'sh000;
  logic servo_pulse, rd_clk_pin, rd_code_pin, rd_gate_pin, index_ff, sample_ff, missed_ff;
  logic gate_a_ff, gate_b_ff, gate_c_ff, rd_valid_ff, sect_done_ff, overrun_ff;
  logic [7:0]  burst_amp, rd_byte_ff, last_byte;
  logic [6:0]  wedge_ff;
  logic [11:0] track_ff, prev;
  logic [20:0] position_ff;
  logic signed [15:0] velocity_ff;
  swd_mode_t   mode_ff;
  logic [1:0]  ecc_need_ff;
  int bad_count = 0, total_checks = 0, n_idx = 0, n_smp = 0, n_miss = 0, n_byte = 0, n_done = 0;
  int b0, ev;
  logic [7:0] q[$];
  always #2 sys_clk = ~sys_clk;
  swd_decoder #(.SECT_BYTES(SECT_N), .FIFO_DEPTH(32)) u_dut (.*);
  swd_chan_model u_model (.servo_pulse, .rd_clk_pin, .rd_code_pin, .rd_gate_pin,
    .burst_amp, .gate_a(gate_a_ff), .gate_b(gate_b_ff), .gate_c(gate_c_ff));
  // Event counters for one-cycle outputs
  always @(posedge sys_clk)
  begin
    if (index_ff === 1'b1) n_idx++;
    if (sample_ff === 1'b1) n_smp++;
    if (missed_ff === 1'b1) n_miss++;
    if (sect_done_ff === 1'b1) n_done++;
    if (rd_valid_ff === 1'b1)
    begin
      n_byte++;
      last_byte = rd_byte_ff;
    end
  end
  // Compare one value
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // Bounded wait until a counter moves past base
  task automatic wait_for(ref int c, input int base, input int lim);
    int n;
    n = 0;
    while (c == base && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == lim)
    begin
      bad_count++;
      stop_test();
    end
  endtask : wait_for
  // Sector with ID, SECT_N data bytes and two check bytes
  task automatic sector(input logic [7:0] id, input logic spoil);
    logic [7:0] c0, c1;
    c0 = 8'h00;
    c1 = 8'h00;
    q = {id};
    for (int i = 0; i < SECT_N; i++)
    begin
      q.push_back(8'(8'h3c + 7 * i));
      if (i % 2 == 0) c0 ^= q[$];
      else c1 ^= q[$];
    end
    q.push_back(c0 ^ {7'h00, spoil});
    q.push_back(c1);
    u_model.send_frame(q);
  endtask : sector
  initial
  begin
    repeat (6) @(posedge sys_clk);
    check("reset_track", {20'h0, track_ff}, 32'h0);
    check("reset_mode", {30'h0, mode_ff}, {30'h0, SWD_FOLLOW});
    check("reset_pulses", {29'h0, index_ff, sample_ff, missed_ff}, 32'h0);
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge sys_clk);
    prev = 12'h000;
    foreach (rows[r])
    begin
      seek_tracks <= rows[r].seek;
      on_track    <= rows[r].on;
      settle_fine <= rows[r].fine;
      act_current <= rows[r].cur;
      {u_model.amp_a, u_model.amp_b, u_model.amp_c} = {rows[r].a, rows[r].b, rows[r].c};
      b0 = n_idx;
      ev = n_smp;
      u_model.send_wedge(rows[r].idx, rows[r].trk ^ (rows[r].trk >> 1), 1'b0);
      wait_for(n_smp, ev, 400);
      check("index", n_idx - b0, {31'h0, rows[r].idx});
      check("track", {20'h0, track_ff}, {20'h0, rows[r].trk});
      check("mode", {30'h0, mode_ff}, {30'h0, rows[r].mode});
      check("wedge", {25'h0, wedge_ff}, r + 1);
      if (rows[r].mode >= SWD_FINE)
        check("pos_fine", {11'h0, position_ff},
              {11'h0, rows[r].trk, 9'(9'h100 + rows[r].a - rows[r].c)});
      else
        check("pos_coarse", {11'h0, position_ff},
              {11'h0, rows[r].trk, rows[r].trk[0] ? rows[r].a : rows[r].b, 1'b0});
      ev = (int'(rows[r].trk) - int'(prev)) * 256 + int'(signed'(rows[r].cur));
      if (r > 0) check("velocity", {16'h0, velocity_ff}, {16'h0, ev[15:0]});
      prev = rows[r].trk;
    end
    // Spoiled mark: missed pulse, old values kept
    b0 = n_miss;
    ev = n_smp;
    u_model.send_wedge(1'b0, 12'h0ff, 1'b1);
    wait_for(n_miss, b0, 400);
    check("no_sample", n_smp - ev, 32'h0);
    check("kept_track", {20'h0, track_ff}, {20'h0, prev});
    // Matching sector, sink ready
    b0 = n_byte;
    ev = n_done;
    sector(8'h5a, 1'b0);
    wait_for(n_done, ev, 300);
    repeat (20) @(posedge sys_clk);
    check("bytes", n_byte - b0, SECT_N);
    check("no_overrun", {31'h0, overrun_ff}, 32'h0);
    check("last_byte", {24'h0, last_byte}, {24'h0, q[SECT_N]});
    check("ecc_none", {30'h0, ecc_need_ff}, 32'h0);
    // Foreign ID: nothing pushed
    b0 = n_byte;
    sector(8'ha5, 1'b0);
    repeat (200) @(posedge sys_clk);
    check("foreign", n_byte - b0, 32'h0);
    // Stalled sink fills the FIFO, spoiled check byte
    rd_ready <= 1'b0;
    ev = n_done;
    sector(8'h5a, 1'b1);
    wait_for(n_done, ev, 300);
    check("ecc_single", {30'h0, ecc_need_ff}, 32'h1);
    check("overrun", {31'h0, overrun_ff}, 32'h1);
    b0 = n_byte;
    rd_ready <= 1'b1;
    repeat (80) @(posedge sys_clk);
    check("drained", n_byte - b0, 32'd32);
    stop_test();
  end
endmodule : servo_wedge_decoder_tb

// *** sim/swd_chan_model.sv ***
// Far-side model: servo pulse stream, burst peak detector, coded read data.
// Assumes the decoder treats every output here except burst_amp as asynchronous to sys_clk.
`timescale 1ns/1ps
module swd_chan_model (
  output logic       servo_pulse,  // Raw servo pulses
  output logic       rd_clk_pin,   // Read clock, still outside frames
  output logic       rd_code_pin,  // Coded read bit
  output logic       rd_gate_pin,  // Sector frame
  output logic [7:0] burst_amp,    // Peak of the gated burst
  input  wire logic  gate_a,       // Burst A gate
  input  wire logic  gate_b,       // Burst B gate
  input  wire logic  gate_c       // Burst C gate
);
  logic [7:0] amp_a = 8'h00;  // Burst amplitudes, set by the bench
  logic [7:0] amp_b = 8'h00;
  logic [7:0] amp_c = 8'h00;
  initial {servo_pulse, rd_clk_pin, rd_code_pin, rd_gate_pin} = 4'h0;
  // Peak answer follows whichever gate is open
  assign burst_amp = gate_a ? amp_a : gate_b ? amp_b : gate_c ? amp_c : 8'h00;
  // One servo digit of 37.5 ns, pulse at its start
  task automatic digit(input logic d);
    servo_pulse = d;
    #12.5;
    servo_pulse = 1'b0;
    #25;
  endtask : digit
  // Send n digits, oldest first
  task automatic bits(input logic [35:0] p, input int n);
    for (int i = n - 1; i >= 0; i--) digit(p[i]);
  endtask : bits
  // Whole wedge; bad spoils the mark
  task automatic send_wedge(input logic idx, input logic [11:0] gray, input logic bad);
    for (int i = 0; i < 33; i++) bits(36'h4, 3);
    bits(bad ? 36'h0 : 36'h800200084, 36);
    bits(idx ? 36'h90 : 36'h84, 8);
    for (int i = 11; i >= 0; i--) bits(gray[i] ? 36'h120 : 36'h108, 9);
    for (int i = 0; i < 150; i++) digit(1'b0);
  endtask : send_wedge
  // One framed sector, two data bits to three code bits
  task automatic send_frame(input logic [7:0] q[$]);
    logic [11:0] tbl;
    logic [2:0]  cw;
    tbl = {3'h2, 3'h1, 3'h4, 3'h5};
    rd_gate_pin = 1'b1;  // Head already chosen by firmware before the frame
    foreach (q[k])
      for (int i = 3; i >= 0; i--)
      begin
        cw = tbl[3 * q[k][2 * i +: 2] +: 3];
        for (int j = 2; j >= 0; j--)
        begin
          rd_code_pin = cw[j];
          #10 rd_clk_pin = 1'b1;
          #20 rd_clk_pin = 1'b0;
          #10;
        end
      end
    rd_gate_pin = 1'b0;
    rd_code_pin = ~rd_code_pin;  // Released line shows no stale value
  endtask : send_frame
endmodule : swd_chan_model
